/* File: rtl/vdac_core.sv */
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "vdac_defs.svh"

module vdac_core #(
    parameter int SLOT_CYCLES = `VDAC_UPDATE_NS / (`VDAC_CLK_PERIOD_NS * `VDAC_NUM_CH)
) (
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    ce,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`VDAC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    self_test_fail,
    input  wire logic                    supply_absent,
    output logic      [23:0]             status_bits,
    output logic      [15:0]             dac_code,
    output logic      [`VDAC_CH_W-1:0]   dac_chan,
    output logic                         dac_load,
    output logic                         dac_fault
);

    // True when an address is an aligned word inside the given channel block.
    function automatic logic block_hit(input logic [`VDAC_ADDR_W-1:0] a,
                                       input logic [`VDAC_ADDR_W-1:0] base);
        block_hit = ((a & `VDAC_BLOCK_MASK) == base) && (a[1:0] == 2'b00);
    endfunction

    // Out-of-range counts fall back to all channels.
    function automatic logic [3:0] eff_count(input logic [3:0] c);
        eff_count = (c == 4'h0 || c > 4'h8) ? 4'h8 : c;
    endfunction

    logic [15:0]             raw_output_word [`VDAC_NUM_CH];
    vdac_pkg::range_t        ch_range        [`VDAC_NUM_CH];
    logic                    ch_opt16        [`VDAC_NUM_CH];
    logic [3:0]              ch_count;
    logic                    self_test_flag;
    logic                    supply_absent_flag;
    logic                    dnv_flag;
    logic [15:0]             slot_cnt;
    logic [`VDAC_CH_W-1:0]   chan_idx;

    // Bus decode.
    wire                     acc      = psel & penable & ~pready;
    wire                     done     = psel & penable & pready & ce;
    wire                     wr_done  = done & pwrite;
    wire                     hit_st   = (paddr == `VDAC_OFF_STATUS);
    wire                     hit_ctrl = (paddr == `VDAC_OFF_CTRL);
    wire                     hit_cfg  = block_hit(paddr, `VDAC_OFF_CFG_BASE);
    wire                     hit_raw  = block_hit(paddr, `VDAC_OFF_RAW_BASE);
    wire [`VDAC_CH_W-1:0]    idx      = paddr[4:2];
    wire                     mapped   = hit_st | hit_ctrl | hit_cfg | hit_raw;
    wire                     bad      = ~mapped | (pwrite & hit_st);
    wire                     wr_ctrl  = wr_done & hit_ctrl;
    wire                     wr_cfg   = wr_done & hit_cfg;
    wire                     wr_raw   = wr_done & hit_raw;
    wire                     commit   = wr_ctrl & pwdata[`VDAC_CTRL_COMMIT];
    wire                     fault    = self_test_flag | supply_absent_flag;

    // Status image: one flag byte and two reserved bytes.
    wire [23:0] next_status = {16'h0000, 5'h00, dnv_flag,
                               supply_absent_flag, self_test_flag};

    // Update sequencer decode.
    wire [3:0]               n_en      = eff_count(ch_count);
    wire                     slot_end  = (slot_cnt == 16'(SLOT_CYCLES - 1));
    // A count lowered mid pass can leave the pointer past the new end; it restarts
    // at zero so that a disabled channel is never loaded.
    wire [`VDAC_CH_W-1:0]    cur_chan  = ({1'b0, chan_idx} < n_en) ? chan_idx : '0;
    wire                     last_ch   = ({1'b0, cur_chan} == n_en - 4'h1);
    wire [`VDAC_CH_W-1:0]    next_chan = last_ch ? '0 : cur_chan + 3'h1;
    wire [15:0]              conv_code;

    // Read data mux.
    wire [31:0] rd_word = hit_st   ? {8'h00, next_status} :
                          hit_ctrl ? {28'h0, ch_count} :
                          hit_cfg  ? {29'h0, ch_opt16[idx], ch_range[idx]} :
                          hit_raw  ? {16'h0, raw_output_word[idx]} : 32'h0;

    vdac_code_convert u_conv (
        .raw       (raw_output_word[cur_chan]),
        .range_sel (ch_range[cur_chan]),
        .opt16     (ch_opt16[cur_chan]),
        .fault     (fault),
        .dac_code  (conv_code)
    );

    // Slave answers one cycle after the access phase starts.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (ce) begin
            pready  <= acc;
            pslverr <= acc & bad;
            prdata  <= (acc & ~pwrite) ? rd_word : 32'h0;
        end
    end

    // Channel count and committed-config tracking.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ch_count <= `VDAC_CTRL_RESET;
            dnv_flag <= 1'b1;
        end else if (ce) begin
            if (wr_ctrl) begin
                ch_count <= pwdata[`VDAC_CTRL_CNT_MSB:`VDAC_CTRL_CNT_LSB];
            end
            if (commit) begin
                dnv_flag <= 1'b0;
            end else if (wr_ctrl | wr_cfg) begin
                dnv_flag <= 1'b1;
            end
        end
    end

    // Fault flags: self-test failure is sticky, supply follows the pin.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            self_test_flag     <= 1'b0;
            supply_absent_flag <= 1'b0;
            status_bits        <= 24'h000004;
        end else if (ce) begin
            self_test_flag     <= self_test_flag | self_test_fail;
            supply_absent_flag <= supply_absent;
            status_bits        <= next_status;
        end
    end

    // Per-channel storage; codes are dropped on fault so that recovery
    // starts from zero volts instead of a stale setpoint.
    genvar g;
    generate
        for (g = 0; g < `VDAC_NUM_CH; g++) begin : g_ch
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    raw_output_word[g] <= 16'h0000;
                    ch_range[g]        <= vdac_pkg::RNG_UNI_10;
                    ch_opt16[g]        <= 1'b0;
                end else if (ce) begin
                    if (fault) begin
                        raw_output_word[g] <= 16'h0000;
                    end else if (wr_raw && idx == g) begin
                        raw_output_word[g] <= pwdata[15:0];
                    end
                    if (wr_cfg && idx == g) begin
                        ch_range[g] <= vdac_pkg::range_t'(pwdata[1:0]);
                        ch_opt16[g] <= pwdata[`VDAC_CFG_OPT16];
                    end
                end
            end
        end
    endgenerate

    // One channel per slot; fewer channels give a shorter full pass.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            slot_cnt  <= 16'h0000;
            chan_idx  <= '0;
            dac_load  <= 1'b0;
            dac_code  <= 16'h0000;
            dac_chan  <= '0;
            dac_fault <= 1'b0;
        end else if (ce) begin
            slot_cnt <= slot_end ? 16'h0000 : slot_cnt + 16'h0001;
            dac_load <= slot_end;
            if (slot_end) begin
                dac_code  <= conv_code;
                dac_chan  <= cur_chan;
                dac_fault <= fault;
                chan_idx  <= next_chan;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // Spacing counter between loads, for the update period check.
    logic [15:0] gap_cnt;
    always_ff @(posedge ref_clk) begin
        if (sys_rst || dac_load) begin
            gap_cnt <= 16'h0000;
        end else if (ce) begin
            gap_cnt <= gap_cnt + 16'h0001;
        end
    end

    chk_dnv_at_reset: assert property (
        $fell(sys_rst) |-> status_bits[`VDAC_ST_DNV])
        else $error("Data not valid clear after reset.");

    chk_dnv_commit: assert property (
        ce && commit |=> !dnv_flag)
        else $error("Commit did not clear data not valid.");

    chk_fault_zero_volt: assert property (
        dac_load && dac_fault |->
            (dac_code == `VDAC_CODE_ZERO_UNI || dac_code == `VDAC_CODE_ZERO_BIP))
        else $error("Fault load not at zero volts.");

    chk_load_spacing: assert property (
        dac_load && ce |-> gap_cnt <= 16'(SLOT_CYCLES))
        else $error("Channel slot longer than allowed.");

    chk_chan_in_range: assert property (
        dac_load |-> {1'b0, dac_chan} < $past(n_en))
        else $error("Loaded channel not enabled.");

    chk_supply_follow: assert property (
        ce |=> status_bits[`VDAC_ST_SUPPLY] == $past(supply_absent, 2) ||
               !$past(ce) || !$past(ce, 2))
        else $error("Supply flag does not follow pin.");

    chk_selftest_sticky: assert property (
        self_test_flag |=> self_test_flag)
        else $error("Self-test flag dropped.");

    chk_reserved_zero: assert property (
        status_bits[23:3] == 21'h0)
        else $error("Reserved status bits set.");

    chk_raw_cleared: assert property (
        ce && fault |=> raw_output_word[0] == 16'h0000)
        else $error("Stored code survived fault.");

    // A low enable must freeze the outputs and the stored codes alike.
    chk_hold_on_stall: assert property (
        !ce |=> $stable(dac_code) && $stable(raw_output_word[0]))
        else $error("State moved while clock enable was low.");

    cov_fault_load: cover property (dac_load && dac_fault);
    cov_commit: cover property (ce && commit);
    cov_last_chan: cover property (dac_load && dac_chan == 3'h7);
    cov_bad_access: cover property (pready && pslverr);

endmodule

/* File: rtl/vdac_defs.svh */
`ifndef VDAC_DEFS_SVH
`define VDAC_DEFS_SVH

// Channel count and bus widths.
`define VDAC_NUM_CH         8
`define VDAC_CH_W           3
`define VDAC_ADDR_W         8

// Register byte offsets.
`define VDAC_OFF_STATUS     8'h00
`define VDAC_OFF_CTRL       8'h04
`define VDAC_OFF_CFG_BASE   8'h20
`define VDAC_OFF_RAW_BASE   8'h40
`define VDAC_BLOCK_MASK     8'hE0

// Status byte field positions.
`define VDAC_ST_SELFTEST    0
`define VDAC_ST_SUPPLY      1
`define VDAC_ST_DNV         2

// Control register fields.
`define VDAC_CTRL_CNT_LSB   0
`define VDAC_CTRL_CNT_MSB   3
`define VDAC_CTRL_COMMIT    8
`define VDAC_CTRL_RESET     4'h8

// Channel configuration fields.
`define VDAC_CFG_RNG_LSB    0
`define VDAC_CFG_RNG_MSB    1
`define VDAC_CFG_OPT16      2

// Output codes and limits.
`define VDAC_CODE_ZERO_UNI  16'h0000
`define VDAC_CODE_ZERO_BIP  16'h8000
`define VDAC_CODE_UNI15_MAX 16'hFFFE
`define VDAC_SIGN_FLIP      16'h8000

// Timing.
`define VDAC_CLK_PERIOD_NS  50
`define VDAC_UPDATE_NS      3000000

`endif

/* File: rtl/vdac_pkg.sv */
package vdac_pkg;

    // Output range selection per channel.
    typedef enum logic [1:0] {
        RNG_UNI_10,
        RNG_UNI_5,
        RNG_BIP_10,
        RNG_BIP_5
    } range_t;

endpackage

/* File: rtl/vdac_code_convert.sv */
`timescale 1ns/1ps
`include "vdac_defs.svh"

module vdac_code_convert (
    input  wire logic [15:0]      raw,
    input  wire vdac_pkg::range_t range_sel,
    input  wire logic             opt16,
    input  wire logic             fault,
    output logic      [15:0]      dac_code
);

    // The converter takes offset binary over the full range, so unipolar
    // zero volts is code zero and bipolar zero volts is mid scale.
    wire        bipolar  = (range_sel == vdac_pkg::RNG_BIP_10) ||
                           (range_sel == vdac_pkg::RNG_BIP_5);
    wire [15:0] zero     = bipolar ? `VDAC_CODE_ZERO_BIP : `VDAC_CODE_ZERO_UNI;
    // A 15-bit code above 32767 is out of range; it clamps at full scale.
    wire [15:0] uni15    = raw[15] ? `VDAC_CODE_UNI15_MAX : {raw[14:0], 1'b0};
    wire [15:0] uni16    = raw;
    wire [15:0] bip      = raw ^ `VDAC_SIGN_FLIP;
    wire [15:0] uni_code = opt16 ? uni16 : uni15;
    wire [15:0] live     = bipolar ? bip : uni_code;

    // Fault mode overrides any code with zero volts.
    assign dac_code = fault ? zero : live;

endmodule

/* File: testbench/vdac_host.sv */
`timescale 1ns/1ps
`include "vdac_defs.svh"
// Host side: APB master plus the host's own engineering-unit scaling.
module vdac_host (
    input  wire logic                    clk,
    output logic                         psel,
    output logic                         penable,
    output logic                         pwrite,
    output logic [`VDAC_ADDR_W-1:0]      paddr,
    output logic [31:0]                  pwdata,
    input  wire logic                    pready
);
    // The bus idles from time zero so reset sees no request.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // Request is held until pready is seen high at an edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Linear mapping; limits are applied only when clamping is chosen.
    function automatic logic [15:0] to_raw(input int e, input int emin, input int emax,
                                           input int rmin, input int rmax, input logic cl);
        int r;
        r = rmin + (e - emin) * (rmax - rmin) / (emax - emin);
        if (cl && r > rmax) r = rmax;
        if (cl && r < rmin) r = rmin;
        return r[15:0];
    endfunction
endmodule

/* File: testbench/vdac_core_tb.sv */
`timescale 1ns/1ps
`include "vdac_defs.svh"
module vdac_core_tb;
    localparam int SLOT = 8;
    logic        ref_clk;
    logic        sys_rst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        self_test_fail;
    logic        supply_absent;
    logic [23:0] status_bits;
    logic [15:0] dac_code;
    logic [2:0]  dac_chan;
    logic        dac_load;
    logic        dac_fault;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          gap = 0;
    int          cnt_m = 8;
    logic        flt_m = 1'b0;
    logic        watch = 1'b0;
    logic [33:0] note;
    logic [33:0] expq[$];
    logic [15:0] raw_m[8];
    logic [2:0]  cfg_m[8];

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    vdac_core #(.SLOT_CYCLES(SLOT)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .self_test_fail(self_test_fail), .supply_absent(supply_absent),
        .status_bits(status_bits), .dac_code(dac_code), .dac_chan(dac_chan),
        .dac_load(dac_load), .dac_fault(dac_fault));
    vdac_host host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Note the expected answer, then run the transfer; one idle edge avoids a double drive.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] er, input logic ee);
        expq.push_back({w, ee, er});
        host.xfer(w, a, d);
        @(posedge ref_clk);
    endtask
    // The status pins lag the flags by one cycle, so they are judged after the read.
    task automatic status_is(input logic [2:0] f);
        apb(1'b0, 8'h00, 32'h0, {29'h0, f}, 1'b0);
        check("status_bits", {29'h0, f}, {8'h00, status_bits});
    endtask
    // Loads are judged only while watch is on, so register writes never race them.
    task automatic observe(input int slots);
        @(posedge ref_clk);
        watch <= 1'b1;
        repeat (slots * SLOT) @(posedge ref_clk);
        watch <= 1'b0;
    endtask
    function automatic logic [15:0] conv(input logic [2:0] ch);
        if (cfg_m[ch][1]) return flt_m ? 16'h8000 : raw_m[ch] ^ 16'h8000;
        if (flt_m) return 16'h0000;
        if (cfg_m[ch][2]) return raw_m[ch];
        return raw_m[ch][15] ? 16'hFFFE : {raw_m[ch][14:0], 1'b0};
    endfunction

    // Each completed transfer retires the oldest note.
    always @(posedge ref_clk) begin
        if (pready === 1'b1 && expq.size() > 0) begin
            note = expq.pop_front();
            check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
            if (!note[33]) check("prdata", note[31:0], prdata);
        end
    end
    // Each load carries a live channel's code, exactly one slot after the last.
    always @(posedge ref_clk) begin
        gap <= gap + 1;
        if (dac_load === 1'b1) begin
            gap <= 1;
            if (watch) begin
                check("dac_code", {16'h0, conv(dac_chan)}, {16'h0, dac_code});
                check("dac_fault", {31'h0, flt_m}, {31'h0, dac_fault});
                check("dac_chan", 32'h1, {31'h0, dac_chan < cnt_m});
                check("load gap", SLOT, gap);
            end
        end
    end
    // Hang guard: the sequence needs a few hundred cycles.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        self_test_fail = 1'b0;
        supply_absent = 1'b0;
        void'($urandom(30468));
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        status_is(3'h4);
        apb(1'b1, 8'h00, 32'h7, 32'h0, 1'b1);
        apb(1'b0, 8'h60, 32'h0, 32'h0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            cfg_m[i] = 3'(i);
            apb(1'b1, 8'(8'h20 + 4 * i), {29'h0, cfg_m[i]}, 32'h0, 1'b0);
        end
        apb(1'b1, 8'h04, 32'h00000008, 32'h0, 1'b0);
        status_is(3'h4);
        apb(1'b1, 8'h04, 32'h00000108, 32'h0, 1'b0);
        status_is(3'h0);
        for (int i = 0; i < 8; i++) raw_m[i] = 16'($urandom);
        raw_m[0] = 16'h7FFF;
        raw_m[1] = 16'h8000;
        raw_m[4] = host.to_raw(1200, 0, 1000, 0, 65535, 1'b1);
        raw_m[5] = host.to_raw(500, 0, 1000, 0, 65535, 1'b1);
        for (int i = 0; i < 8; i++) apb(1'b1, 8'(8'h40 + 4 * i), {16'h0, raw_m[i]}, 0, 1'b0);
        observe(16);
        cnt_m = 3;
        apb(1'b1, 8'h04, 32'h00000103, 32'h0, 1'b0);
        observe(9);
        supply_absent <= 1'b1;
        repeat (3) @(posedge ref_clk);
        flt_m = 1'b1;
        foreach (raw_m[i]) raw_m[i] = 16'h0000;
        status_is(3'h2);
        observe(6);
        supply_absent <= 1'b0;
        repeat (3) @(posedge ref_clk);
        flt_m = 1'b0;
        status_is(3'h0);
        observe(6);
        // A short enable stall; two idle slots let the load spacing settle again.
        ce <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ce <= 1'b1;
        repeat (2 * SLOT) @(posedge ref_clk);
        self_test_fail <= 1'b1;
        @(posedge ref_clk);
        self_test_fail <= 1'b0;
        repeat (3) @(posedge ref_clk);
        flt_m = 1'b1;
        cnt_m = 8;
        apb(1'b1, 8'h04, 32'h00000100, 32'h0, 1'b0);
        status_is(3'h1);
        observe(16);
        wrap_up();
    end
endmodule
